// ### logic/periph_dma_channel_regs.sv
// periph_dma_channel_regs: receive and transmit DMA channel with chained
// next buffers, APB register file, enable commands and event interrupt.
// Assumes the peripheral raises rx_ready / tx_ready as levels and a memory
// port that answers with a one-cycle mem_done per request.
//
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/1ns
`default_nettype none

module periph_dma_channel_regs (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_ready,
  input wire logic tx_ready,
  output periph_dma_pkg::mem_req_t mem_req,
  input wire logic mem_done,
  output logic irq
);
  import periph_dma_pkg::*;

  // ************************************************************
  // state
  // ************************************************************
  typedef enum {st_idle, st_rx_busy, st_tx_busy} dma_state_t;

  dma_state_t state_q;
  buffer_t rx_cur_q, rx_nxt_q, tx_cur_q, tx_nxt_q;
  logic rx_on_q, tx_on_q;
  logic [event_bits-1:0] status_q, mask_q;
  xfer_width_t width_q;
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q, irq_q;
  mem_req_t mem_req_q;

  // ************************************************************
  // bus decode
  // ************************************************************
  function automatic logic is_mapped(input logic [11:0] a);
    unique case (a)
      rx_current_address_off, rx_current_count_off, tx_current_address_off,
      tx_remaining_count_off, rx_chained_address_off, rx_chained_count_off,
      tx_chained_address_off, tx_chained_count_off, transfer_command_off,
      transfer_enable_state_off, event_status_off, event_mask_off,
      transfer_width_off: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction : is_mapped

  function automatic logic [31:0] step_of(input xfer_width_t w);
    unique case (w)
      width_half: step_of = 32'h0000_0002;
      width_word: step_of = 32'h0000_0004;
      default: step_of = 32'h0000_0001;
    endcase
  endfunction : step_of

  // ************************************************************
  // per-direction helpers
  // ************************************************************
  // one finished transfer: pointer steps by the width, count drops by one
  function automatic buffer_t advance(input buffer_t b, input xfer_width_t w);
    buffer_t n;
    n.addr = b.addr + step_of(w);
    n.count = b.count - 16'h0001;
    return n;
  endfunction : advance

  function automatic logic is_last(input buffer_t b);
    return b.count == 16'h0001;
  endfunction : is_last

  function automatic logic [31:0] count_word(input logic [15:0] c);
    return {16'h0000, c};
  endfunction : count_word

  // one wait state: pready_q rises one edge into the access phase, so every
  // transfer takes 3 cycles; read data is fetched in the first access cycle
  // and a write lands only at the edge at which the master sees pready high
  logic access, answer, wr, rd;
  assign access = psel && penable && !pready_q;
  assign answer = psel && penable && pready_q;
  assign wr = answer && pwrite;
  assign rd = access && !pwrite;

  function automatic logic wr_at(input logic w, input logic [11:0] a, input logic [11:0] o);
    wr_at = w && (a == o);
  endfunction : wr_at

  logic wr_rx_ca, wr_rx_cc, wr_tx_ca, wr_tx_cc, wr_rx_na, wr_rx_nc, wr_tx_na, wr_tx_nc;
  logic wr_cmd, wr_stat, wr_mask, wr_width;
  assign wr_rx_ca = wr_at(wr, paddr, rx_current_address_off);
  assign wr_rx_cc = wr_at(wr, paddr, rx_current_count_off);
  assign wr_tx_ca = wr_at(wr, paddr, tx_current_address_off);
  assign wr_tx_cc = wr_at(wr, paddr, tx_remaining_count_off);
  assign wr_rx_na = wr_at(wr, paddr, rx_chained_address_off);
  assign wr_rx_nc = wr_at(wr, paddr, rx_chained_count_off);
  assign wr_tx_na = wr_at(wr, paddr, tx_chained_address_off);
  assign wr_tx_nc = wr_at(wr, paddr, tx_chained_count_off);
  assign wr_cmd = wr_at(wr, paddr, transfer_command_off);
  assign wr_stat = wr_at(wr, paddr, event_status_off);
  assign wr_mask = wr_at(wr, paddr, event_mask_off);
  assign wr_width = wr_at(wr, paddr, transfer_width_off);

  // ************************************************************
  // transfer engine
  // ************************************************************
  // receive is served ahead of transmit when both ask in the same cycle
  logic rx_go, tx_go, rx_fin, tx_fin;
  assign rx_go = (state_q == st_idle) && rx_on_q && rx_ready && (rx_cur_q.count != count_reset);
  assign tx_go = (state_q == st_idle) && !rx_go && tx_on_q && tx_ready
               && (tx_cur_q.count != count_reset);
  assign rx_fin = (state_q == st_rx_busy) && mem_done;
  assign tx_fin = (state_q == st_tx_busy) && mem_done;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= st_idle;
    end else begin
      unique case (state_q)
        st_idle: begin
          if (rx_go) begin
            state_q <= st_rx_busy;
          end else if (tx_go) begin
            state_q <= st_tx_busy;
          end
        end
        st_rx_busy: begin
          if (mem_done) begin
            state_q <= st_idle;
          end
        end
        st_tx_busy: begin
          if (mem_done) begin
            state_q <= st_idle;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mem_req_q <= '0;
    end else if (rx_go || tx_go) begin
      mem_req_q.valid <= 1'b1;
      mem_req_q.write <= rx_go;
      mem_req_q.addr <= rx_go ? rx_cur_q.addr : tx_cur_q.addr;
      mem_req_q.size <= width_q;
    end else if (mem_done) begin
      mem_req_q.valid <= 1'b0;
    end
  end

  // ************************************************************
  // pointers and counters, one block per direction
  // ************************************************************
  // a software write to a count or address in the completing cycle wins,
  // so the new value is never overwritten by the stale step
  logic rx_cur_zero_d, tx_cur_zero_d;
  assign rx_cur_zero_d = rx_fin && is_last(rx_cur_q);
  assign tx_cur_zero_d = tx_fin && is_last(tx_cur_q);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_cur_q <= '{addr: address_reset, count: count_reset};
      rx_nxt_q <= '{addr: address_reset, count: count_reset};
    end else begin
      if (rx_cur_zero_d && rx_nxt_q.count != count_reset) begin
        rx_cur_q <= rx_nxt_q;
        rx_nxt_q.count <= count_reset;
      end else if (rx_fin) begin
        rx_cur_q <= advance(rx_cur_q, width_q);
      end
      if (wr_rx_ca) begin
        rx_cur_q.addr <= pwdata;
      end
      if (wr_rx_cc) begin
        rx_cur_q.count <= pwdata[15:0];
      end
      if (wr_rx_na) begin
        rx_nxt_q.addr <= pwdata;
      end
      if (wr_rx_nc) begin
        rx_nxt_q.count <= pwdata[15:0];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_cur_q <= '{addr: address_reset, count: count_reset};
      tx_nxt_q <= '{addr: address_reset, count: count_reset};
    end else begin
      if (tx_cur_zero_d && tx_nxt_q.count != count_reset) begin
        tx_cur_q <= tx_nxt_q;
        tx_nxt_q.count <= count_reset;
      end else if (tx_fin) begin
        tx_cur_q <= advance(tx_cur_q, width_q);
      end
      if (wr_tx_ca) begin
        tx_cur_q.addr <= pwdata;
      end
      if (wr_tx_cc) begin
        tx_cur_q.count <= pwdata[15:0];
      end
      if (wr_tx_na) begin
        tx_nxt_q.addr <= pwdata;
      end
      if (wr_tx_nc) begin
        tx_nxt_q.count <= pwdata[15:0];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      width_q <= xfer_width_t'(width_reset);
    end else if (wr_width) begin
      width_q <= xfer_width_t'(pwdata[1:0]);
    end
  end

  // ************************************************************
  // request enables
  // ************************************************************
  // a disable written together with its enable wins in both directions
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_on_q <= 1'b0;
    end else if (wr_cmd) begin
      if (pwdata[rx_requests_off_bit]) begin
        rx_on_q <= 1'b0;
      end else if (pwdata[rx_requests_on_bit]) begin
        rx_on_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_on_q <= 1'b0;
    end else if (wr_cmd) begin
      if (pwdata[tx_requests_off_bit]) begin
        tx_on_q <= 1'b0;
      end else if (pwdata[tx_requests_on_bit]) begin
        tx_on_q <= 1'b1;
      end
    end
  end

  // ************************************************************
  // events and interrupt
  // ************************************************************
  // end flags are hardware-set with set winning over both clears
  logic [event_bits-1:0] ev_set, ev_clr;
  always_comb begin
    ev_set = '0;
    ev_set[rx_buffer_end_bit] = rx_cur_zero_d;
    ev_set[rx_all_full_bit] = rx_cur_zero_d && (rx_nxt_q.count == count_reset);
    ev_set[tx_buffer_end_bit] = tx_cur_zero_d;
    ev_set[tx_all_empty_bit] = tx_cur_zero_d && (tx_nxt_q.count == count_reset);
    ev_clr = wr_stat ? pwdata[event_bits-1:0] : '0;
    if (wr_rx_cc || wr_rx_nc) begin
      ev_clr[rx_buffer_end_bit] = 1'b1;
    end
    if (wr_tx_cc || wr_tx_nc) begin
      ev_clr[tx_buffer_end_bit] = 1'b1;
    end
  end

  // next status also feeds irq, so the line moves on the same edge as status
  logic [event_bits-1:0] status_d;
  assign status_d = (status_q & ~ev_clr) | ev_set;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_q <= '0;
    end else begin
      status_q <= status_d;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mask_q <= '0;
    end else if (wr_mask) begin
      mask_q <= pwdata[event_bits-1:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(status_d & mask_q);
    end
  end

  // ************************************************************
  // read path and answer
  // ************************************************************
  // pslverr rides on pready; an unmapped write changes nothing
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= access;
      pslverr_q <= access && !is_mapped(paddr);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata_q <= 32'h0000_0000;
    end else begin
      prdata_q <= 32'h0000_0000;
      if (rd) begin
        unique case (paddr)
          rx_current_address_off: prdata_q <= rx_cur_q.addr;
          rx_current_count_off: prdata_q <= count_word(rx_cur_q.count);
          tx_current_address_off: prdata_q <= tx_cur_q.addr;
          tx_remaining_count_off: prdata_q <= count_word(tx_cur_q.count);
          rx_chained_address_off: prdata_q <= rx_nxt_q.addr;
          rx_chained_count_off: prdata_q <= count_word(rx_nxt_q.count);
          tx_chained_address_off: prdata_q <= tx_nxt_q.addr;
          tx_chained_count_off: prdata_q <= count_word(tx_nxt_q.count);
          transfer_enable_state_off: begin
            prdata_q[rx_requests_on_bit] <= rx_on_q;
            prdata_q[tx_requests_on_bit] <= tx_on_q;
          end
          event_status_off: prdata_q <= {28'h0000000, status_q};
          event_mask_off: prdata_q <= {28'h0000000, mask_q};
          transfer_width_off: prdata_q <= {30'h00000000, width_q};
          default: prdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign mem_req = mem_req_q;
  assign irq = irq_q;

endmodule : periph_dma_channel_regs

`default_nettype wire

// ### logic/periph_dma_pkg.sv
// periph_dma_pkg: register map, field positions, reset values and carriers
// of the peripheral DMA channel pair. Assumes a 32-bit APB slave port.
package periph_dma_pkg;

  // ************************************************************
  // register byte offsets
  // ************************************************************
  localparam logic [11:0] rx_current_address_off = 12'h100;
  localparam logic [11:0] rx_current_count_off = 12'h104;
  localparam logic [11:0] tx_current_address_off = 12'h108;
  localparam logic [11:0] tx_remaining_count_off = 12'h10C;
  localparam logic [11:0] rx_chained_address_off = 12'h110;
  localparam logic [11:0] rx_chained_count_off = 12'h114;
  localparam logic [11:0] tx_chained_address_off = 12'h118;
  localparam logic [11:0] tx_chained_count_off = 12'h11C;
  localparam logic [11:0] transfer_command_off = 12'h120;
  localparam logic [11:0] transfer_enable_state_off = 12'h124;
  localparam logic [11:0] event_status_off = 12'h128;
  localparam logic [11:0] event_mask_off = 12'h12C;
  localparam logic [11:0] transfer_width_off = 12'h130;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int rx_requests_on_bit = 0;
  localparam int rx_requests_off_bit = 1;
  localparam int tx_requests_on_bit = 8;
  localparam int tx_requests_off_bit = 9;
  localparam int rx_buffer_end_bit = 0;
  localparam int rx_all_full_bit = 1;
  localparam int tx_buffer_end_bit = 2;
  localparam int tx_all_empty_bit = 3;
  localparam int event_bits = 4;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [31:0] address_reset = 32'h0000_0000;
  localparam logic [15:0] count_reset = 16'h0000;
  localparam logic [1:0] width_reset = 2'h0;

  // transfer width codes: byte, half-word, word
  typedef enum logic [1:0] {width_byte, width_half, width_word, width_rsvd} xfer_width_t;

  // one direction's pointer and counter pair
  typedef struct packed {
    logic [31:0] addr;
    logic [15:0] count;
  } buffer_t;

  // memory transfer request towards the system bus
  typedef struct packed {
    logic valid;
    logic write;
    logic [31:0] addr;
    logic [1:0] size;
  } mem_req_t;

endpackage : periph_dma_pkg

// ### dv/periph_dma_props.sv
// periph_dma_props: port checker for the DMA channel pair.
// Assumes one clock domain and the active-high asynchronous reset.
`timescale 1ns/1ns
`default_nettype none
module periph_dma_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rx_ready,
  input wire logic tx_ready,
  input wire periph_dma_pkg::mem_req_t mem_req,
  input wire logic mem_done,
  input wire logic irq
);
  import periph_dma_pkg::*;
  // ************************************************************
  // properties
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic acc;
  assign acc = psel && penable && !pready;
  apb_answer_a: assert property (acc |=> pready)
    else $error("no answer one cycle after access");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held past one cycle");
  err_pulse_a: assert property (pslverr |-> pready)
    else $error("error flag without ready");
  idle_data_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  cmd_read_a: assert property (acc && !pwrite && paddr == 12'h120 |=> prdata == 32'h0)
    else $error("command register read not zero");
  req_hold_a: assert property (mem_req.valid && !mem_done |=> $stable(mem_req))
    else $error("memory request changed while pending");
  req_end_a: assert property (mem_done && mem_req.valid |=> !mem_req.valid)
    else $error("memory request kept after done");
  rx_cause_a: assert property ($rose(mem_req.valid) && mem_req.write |-> $past(rx_ready))
    else $error("receive request without ready");
  tx_cause_a: assert property ($rose(mem_req.valid) && !mem_req.write |-> $past(tx_ready))
    else $error("transmit request without ready");
  rx_off_a: assert property (psel && penable && pready && pwrite
    && paddr == 12'h120 && pwdata[1]
    |-> ##2 !($rose(mem_req.valid) && mem_req.write) [*2])
    else $error("receive request after disable");
  cover property (mem_done && mem_req.write);
  cover property (mem_done && !mem_req.write);
  cover property (pslverr);
  cover property ($rose(irq));
endmodule : periph_dma_props
bind periph_dma_channel_regs periph_dma_props props (.clk, .rst, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .rx_ready, .tx_ready, .mem_req, .mem_done,
  .irq);
`default_nettype wire

// ### dv/periph_far_model.sv
// periph_far_model: peripheral ready levels and the memory port answer.
// Assumes mem_req stays up until mem_done is seen.
`timescale 1ns/1ns
`default_nettype none
module periph_far_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic rx_want,
  input wire logic tx_want,
  input wire logic slow,
  input wire periph_dma_pkg::mem_req_t mem_req,
  output logic rx_ready,
  output logic tx_ready,
  output logic mem_done
);
  import periph_dma_pkg::*;
  logic [3:0] wait_q;
  assign rx_ready = rx_want;
  assign tx_ready = tx_want;
  // slow mode stretches each memory access to exercise request holding
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_q <= 4'h0;
      mem_done <= 1'b0;
    end else begin
      mem_done <= 1'b0;
      if (mem_req.valid && !mem_done) begin
        wait_q <= wait_q + 4'h1;
        if (wait_q == (slow ? 4'h5 : 4'h0)) begin
          mem_done <= 1'b1;
          wait_q <= 4'h0;
        end
      end
    end
  end
endmodule : periph_far_model
`default_nettype wire

// ### dv/periph_dma_channel_regs_tb_top.sv
// periph_dma_channel_regs_tb_top: directed bench for the DMA channel pair.
// Assumes the far-side model answers memory requests and drives ready levels.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module periph_dma_channel_regs_tb_top;
  import periph_dma_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, rx_ready, tx_ready, mem_done, irq;
  logic rx_want = 1'b0;
  logic tx_want = 1'b0;
  logic slow = 1'b0;
  mem_req_t mem_req;
  int num_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  logic [34:0] seen[$];
  always #2 clk = ~clk;
  periph_dma_channel_regs dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .rx_ready, .tx_ready, .mem_req, .mem_done, .irq);
  periph_far_model far (.clk, .rst, .rx_want, .tx_want, .slow, .mem_req, .rx_ready,
    .tx_ready, .mem_done);
  // ************************************************************
  // monitor, timeout and tasks
  // ************************************************************
  always @(posedge clk) begin
    if (mem_done === 1'b1 && mem_req.valid === 1'b1)
      seen.push_back({mem_req.write, mem_req.size, mem_req.addr});
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("errors %0d checks %0d", num_errors, num_checks);
    if (num_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    `CHK($sformatf("reg %0h", a), x, r)
  endtask : rd
  task automatic check_regs();
    logic [11:0] offs[5] = '{12'h10C, 12'h110, 12'h114, 12'h118, 12'h11C};
    logic [31:0] keep[5] = '{32'hFFFF, 32'hFFFFFFFF, 32'hFFFF, 32'hFFFFFFFF, 32'hFFFF};
    for (int i = 0; i < 5; i++) begin
      rd(offs[i], 32'h0);
      wr(offs[i], 32'hFFFFFFFF);
      rd(offs[i], keep[i]);
      wr(offs[i], 32'h0);
    end
  endtask : check_regs
  task automatic check_cmds();
    logic [31:0] cmd[8] = '{32'h001, 32'h000, 32'h003, 32'h100, 32'h000, 32'h300, 32'h101,
                            32'h202};
    logic [31:0] st[8] = '{32'h001, 32'h001, 32'h000, 32'h100, 32'h100, 32'h000, 32'h101,
                           32'h000};
    logic [31:0] r;
    logic e;
    for (int i = 0; i < 8; i++) begin
      wr(12'h120, cmd[i]);
      rd(12'h124, st[i]);
    end
    wr(12'h124, 32'h101);
    rd(12'h124, 32'h0);
    rd(12'h120, 32'h0);
    apb(1'b0, 12'h200, 32'h0, r, e);
    `CHK("unmapped error", 1'b1, e)
  endtask : check_cmds
  task automatic xfer(input logic rx, input logic [1:0] w, input int step, input int n1,
                      input int n2);
    logic [11:0] o;
    logic [31:0] ad;
    int k;
    o = rx ? 12'h100 : 12'h108;
    seen.delete();
    wr(12'h130, {30'h0, w});
    wr(o, 32'h2000_0000);
    wr(o + 12'h4, 32'(n1));
    wr(o + 12'h10, 32'h3000_0000);
    wr(o + 12'h14, 32'(n2));
    wr(12'h12C, 32'h0000_000F);
    rx_want <= rx;
    tx_want <= !rx;
    wr(12'h120, rx ? 32'h1 : 32'h100);
    k = 0;
    while (seen.size() < n1 + n2 && k < 300) begin
      @(posedge clk);
      k++;
    end
    // a stray extra transfer would land within this idle stretch
    repeat (20) @(posedge clk);
    `CHK("transfer count", n1 + n2, seen.size())
    for (int i = 0; i < seen.size() && i < n1 + n2; i++) begin
      ad = i < n1 ? 32'h2000_0000 + 32'(i * step) : 32'h3000_0000 + 32'((i - n1) * step);
      `CHK("memory request", {rx, w, ad}, seen[i])
    end
    rd(o + 12'h14, 32'h0);
    rd(o + 12'h4, 32'h0);
    rd(12'h128, rx ? 32'h3 : 32'hC);
    `CHK("irq raised", 1'b1, irq)
    wr(12'h12C, 32'h0);
    repeat (2) @(posedge clk);
    `CHK("irq masked", 1'b0, irq)
    wr(o + 12'h14, 32'h0);
    rd(12'h128, rx ? 32'h2 : 32'h8);
    wr(12'h128, 32'hF);
    wr(12'h12C, 32'hF);
    repeat (2) @(posedge clk);
    `CHK("irq cleared", 1'b0, irq)
    wr(12'h120, rx ? 32'h2 : 32'h200);
    rx_want <= 1'b0;
    tx_want <= 1'b0;
  endtask : xfer
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    check_regs();
    check_cmds();
    xfer(1'b0, 2'h2, 4, 2, 1);
    slow <= 1'b1;
    xfer(1'b1, 2'h0, 1, 1, 2);
    xfer(1'b1, 2'h1, 2, 2, 0);
    complete_run();
  end
endmodule : periph_dma_channel_regs_tb_top
`default_nettype wire
